// [logic/pmsf_params.svh]
`ifndef PMSF_PARAMS_SVH
`define PMSF_PARAMS_SVH
// ****************************************************************
// clock and times
// ****************************************************************
`define PMSF_CLK_MHZ        100
`define PMSF_T_RESTORE_MS   30
`define PMSF_T_MASS_MS      100
`define PMSF_T_LONG_US      500
`define PMSF_T_SHORT_US     50
`define PMSF_T_TOFF_US      1000
// ****************************************************************
// bus addresses
// ****************************************************************
`define PMSF_ADDR_GLOBAL    7'h5B
`define PMSF_ADDR_ARA       7'h0C
`define PMSF_BASE_RST       7'h5C
// ****************************************************************
// command codes
// ****************************************************************
`define PMSF_C_PAGE         8'h00
`define PMSF_C_OPER         8'h01
`define PMSF_C_ONOFF        8'h02
`define PMSF_C_CLRF         8'h03
`define PMSF_C_WLOCK        8'h10
`define PMSF_C_STORE        8'h15
`define PMSF_C_RESTORE      8'h16
`define PMSF_C_CAPS         8'h19
`define PMSF_C_VFMT         8'h20
`define PMSF_C_VCMD         8'h21
`define PMSF_C_VMAX         8'h24
`define PMSF_C_MHI          8'h25
`define PMSF_C_MLO          8'h26
`define PMSF_C_VINON        8'h35
`define PMSF_C_VINOFF       8'h36
`define PMSF_C_SGAIN        8'h38
`define PMSF_C_SOFFS        8'h39
`define PMSF_C_OVL          8'h40
`define PMSF_C_OVA          8'h41
`define PMSF_C_OVW          8'h42
`define PMSF_C_UVW          8'h43
`define PMSF_C_UVL          8'h44
`define PMSF_C_TRISE        8'h61
`define PMSF_C_AUX0         8'hC9
`define PMSF_C_AUX1         8'hCA
`define PMSF_C_CONFIG       8'hD0
`define PMSF_C_DAC          8'hE0
`define PMSF_C_STATUS       8'hE5
`define PMSF_C_BASE         8'hE6
`define PMSF_C_ISGAIN       8'hE8
// ****************************************************************
// reset values and fields
// ****************************************************************
`define PMSF_R_PAGE         8'h00
`define PMSF_R_OPER         8'h00
`define PMSF_R_ONOFF        8'h1E
`define PMSF_R_WLOCK        8'h00
`define PMSF_V_CAPS         8'hB0
`define PMSF_V_VFMT         8'h13
`define PMSF_R_VCMD         16'h2000
`define PMSF_R_VMAX         16'h8000
`define PMSF_R_MHI          16'h219A
`define PMSF_R_MLO          16'h1E66
`define PMSF_R_VINON        16'hD280
`define PMSF_R_VINOFF       16'hD240
`define PMSF_R_SGAIN        16'hBA00
`define PMSF_R_SOFFS        16'h8000
`define PMSF_R_OVL          16'h2333
`define PMSF_R_OVA          8'h80
`define PMSF_R_OVW          16'h2266
`define PMSF_R_UVW          16'h1D9A
`define PMSF_B_READY        6
`define PMSF_B_ON           7
`endif

// [logic/pmsf_pkg.sv]
package pmsf_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CMD  = 3'b010,
    PH_WR   = 3'b011,
    PH_RD   = 3'b100,
    PH_SKIP = 3'b101
  } pmsf_phase_e;

  typedef struct packed {
    logic [7:0]  oper;
    logic [7:0]  onoff;
    logic [15:0] vcmd;
    logic [15:0] vmax;
    logic [15:0] mhi;
    logic [15:0] mlo;
    logic [15:0] sgain;
    logic [15:0] soffs;
    logic [15:0] ovl;
    logic [7:0]  ova;
    logic [15:0] ovw;
    logic [15:0] uvw;
  } pmsf_page_s;

  typedef struct packed {
    logic [1:0] low_digit;
    logic [1:0] high_digit;
  } pmsf_strap_s;
endpackage : pmsf_pkg

// [logic/pmsf_top.sv]
`timescale 1ns/1ps
`include "pmsf_params.svh"
// Behaviour
// - answer at base address plus strap offset
// - offset is three times high plus low
// - base address register resets to 0x5C
// - base address register takes the low seven bits of any written byte
// - always answer global and alert response addresses
// - status read allowed and faultless while busy
// - status bit 6 low while busy
// - busy command: nack, latch fault, pull alert
// - memory commands hold busy for long times
// - gain writes hold busy 500 us, trim writes 50 us
// - fault clear never enters busy
// - channel select register picks paged copy
// - per-channel mode byte and on/off source
// - send byte clears selected page faults
// - send bytes pulse store and restore request outputs
// - voltage format reads fixed 0x13
// - input voltage hysteresis gates both enables
// - ceiling caps every commanded voltage
// - protocol_capabilities byte reads fixed 0xB0
// - accept packet error code on byte and word writes, group framing only when addressed last
// - slave transaction set incl alert response
module pmsf_top #(
  parameter int unsigned RESTORE_CYC = `PMSF_T_RESTORE_MS * 1000 * `PMSF_CLK_MHZ,
  parameter int unsigned STORE_CYC   = `PMSF_T_MASS_MS * 1000 * `PMSF_CLK_MHZ,
  parameter int unsigned LONG_CYC    = `PMSF_T_LONG_US * `PMSF_CLK_MHZ,
  parameter int unsigned SHORT_CYC   = `PMSF_T_SHORT_US * `PMSF_CLK_MHZ,
  parameter int unsigned TOFF_CYC    = `PMSF_T_TOFF_US * `PMSF_CLK_MHZ
) (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output wire logic                 sda_out,
  output wire logic                 sda_oe_n,
  input  wire pmsf_pkg::pmsf_strap_s strap_in,
  output wire logic                 alert_out_n,
  output wire logic                 alert_oe_n,
  input  wire logic [15:0]          vin_meas,
  input  wire logic                 input_off_threshold_delayed,
  input  wire logic [1:0]           fault_event,
  output wire logic [1:0]           fault_latched,
  output wire logic [1:0]           output_enable_pin,
  output wire logic [15:0]          vout_setpoint0,
  output wire logic [15:0]          vout_setpoint1,
  output wire logic                 nvm_store_req,
  output wire logic                 nvm_restore_req
);
  import pmsf_pkg::*;

  // ****************************************************************
  // pin synchronisers and bus events
  // ****************************************************************
  logic [1:0] scl_sync_r, sda_sync_r;
  logic       scl_d_r, sda_d_r;
  pmsf_strap_s strap_s1_r, strap_s2_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
      strap_s1_r <= strap_in;
      strap_s2_r <= strap_s1_r;
    end
  end

  wire logic scl_s    = scl_sync_r[1];
  wire logic sda_s    = sda_sync_r[1];
  wire logic scl_rise = scl_s & ~scl_d_r;
  wire logic scl_fall = ~scl_s & scl_d_r;
  wire logic start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire logic stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic [3:0] level3(input logic [1:0] code);
    level3 = (code > 2'h2) ? 4'h2 : {2'b00, code};
  endfunction : level3

  logic [6:0] base_r;
  wire logic [3:0] strap_n  = 4'(3 * level3(strap_s2_r.high_digit))
                            + level3(strap_s2_r.low_digit);
  wire logic [6:0] own_addr = base_r + {3'b000, strap_n};

  // ****************************************************************
  // serial engine
  // ****************************************************************
  pmsf_phase_e ph_r;
  logic [3:0]  bitcnt_r;
  logic        ack_slot_r;
  logic [7:0]  sh_r, tx_r, cmd_r, lo_r, hi_r;
  logic [1:0]  wcnt_r;
  logic        rdhi_r, ara_r, oe_n_r, busy_fault_r, alert_r;
  logic [24:0] busy_cnt_r;
  logic [7:0]  page_r, wlock_r;
  logic [15:0] input_on_threshold_r, input_off_threshold_r;
  pmsf_page_s  pg_r [2];

  wire logic       busy    = busy_cnt_r != 25'h000_0000;
  wire logic       sel     = page_r[0];
  wire logic [7:0] byte_in = sh_r;
  wire logic [6:0] a_in    = byte_in[7:1];
  wire logic       a_hit   = (a_in == own_addr) | (a_in == `PMSF_ADDR_GLOBAL)
                           | ((a_in == `PMSF_ADDR_ARA) & byte_in[0]);
  wire logic       a_ara   = (a_in == `PMSF_ADDR_ARA) & byte_in[0];
  wire logic       c_ok    = ~busy | (byte_in == `PMSF_C_STATUS);
  wire logic [7:0] status_b = {1'b0, ~busy, 4'h0, busy_fault_r, |fault_latched};

  function automatic logic [15:0] rd_mux(input logic [7:0] c, input pmsf_page_s p);
    unique case (c)
      `PMSF_C_PAGE:    rd_mux = {8'h00, page_r};
      `PMSF_C_OPER:    rd_mux = {8'h00, p.oper};
      `PMSF_C_ONOFF:   rd_mux = {8'h00, p.onoff};
      `PMSF_C_WLOCK:   rd_mux = {8'h00, wlock_r};
      `PMSF_C_CAPS:    rd_mux = {8'h00, `PMSF_V_CAPS};
      `PMSF_C_VFMT:    rd_mux = {8'h00, `PMSF_V_VFMT};
      `PMSF_C_VCMD:    rd_mux = p.vcmd;
      `PMSF_C_VMAX:    rd_mux = p.vmax;
      `PMSF_C_MHI:     rd_mux = p.mhi;
      `PMSF_C_MLO:     rd_mux = p.mlo;
      `PMSF_C_VINON:   rd_mux = input_on_threshold_r;
      `PMSF_C_VINOFF:  rd_mux = input_off_threshold_r;
      `PMSF_C_SGAIN:   rd_mux = p.sgain;
      `PMSF_C_SOFFS:   rd_mux = p.soffs;
      `PMSF_C_OVL:     rd_mux = p.ovl;
      `PMSF_C_OVA:     rd_mux = {8'h00, p.ova};
      `PMSF_C_OVW:     rd_mux = p.ovw;
      `PMSF_C_UVW:     rd_mux = p.uvw;
      `PMSF_C_STATUS:  rd_mux = {8'h00, status_b};
      `PMSF_C_BASE:    rd_mux = {9'h000, base_r};
      default:         rd_mux = 16'h0000;
    endcase
  endfunction : rd_mux

  wire logic [15:0] rd_word = rd_mux(cmd_r, pg_r[sel]);

  // a repeated start keeps the command byte so combined reads work
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ph_r <= PH_IDLE;
      bitcnt_r <= 4'h0;
      ack_slot_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'hFF;
      cmd_r <= 8'h00;
      lo_r <= 8'h00;
      hi_r <= 8'h00;
      wcnt_r <= 2'h0;
      rdhi_r <= 1'b0;
      ara_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (start_ev) begin
      ph_r <= PH_ADDR;
      bitcnt_r <= 4'h0;
      ack_slot_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (stop_ev) begin
      ph_r <= PH_IDLE;
      oe_n_r <= 1'b1;
    end else if (scl_rise && ph_r != PH_IDLE) begin
      if (!ack_slot_r) begin
        sh_r <= {sh_r[6:0], sda_s};
        bitcnt_r <= bitcnt_r + 4'h1;
      end else if (ph_r == PH_RD && oe_n_r) begin
        if (sda_s) begin
          ph_r <= PH_SKIP;
        end else begin
          tx_r <= rdhi_r ? rd_word[15:8] : 8'h00;
          rdhi_r <= 1'b0;
        end
      end
    end else if (scl_fall && ph_r != PH_IDLE && ph_r != PH_SKIP) begin
      if (!ack_slot_r && bitcnt_r == 4'h8) begin
        ack_slot_r <= 1'b1;
        unique case (ph_r)
          PH_ADDR: begin
            oe_n_r <= ~a_hit;
            ara_r <= a_ara;
            if (!a_hit) begin
              ph_r <= PH_SKIP;
            end else if (byte_in[0]) begin
              ph_r <= PH_RD;
              tx_r <= a_ara ? {own_addr, 1'b0} : rd_word[7:0];
              rdhi_r <= ~a_ara;
            end else begin
              ph_r <= PH_CMD;
            end
          end
          PH_CMD: begin
            oe_n_r <= ~c_ok;
            cmd_r <= byte_in;
            wcnt_r <= 2'h0;
            ph_r <= c_ok ? PH_WR : PH_SKIP;
          end
          PH_WR: begin
            oe_n_r <= 1'b0;
            if (wcnt_r == 2'h0) lo_r <= byte_in;
            if (wcnt_r == 2'h1) hi_r <= byte_in;
            if (wcnt_r != 2'h3) wcnt_r <= wcnt_r + 2'h1;
          end
          default: oe_n_r <= 1'b1;
        endcase
      end else if (ack_slot_r) begin
        ack_slot_r <= 1'b0;
        bitcnt_r <= 4'h0;
        oe_n_r <= (ph_r == PH_RD) ? tx_r[7] : 1'b1;
        tx_r <= {tx_r[6:0], 1'b1};
      end else if (ph_r == PH_RD) begin
        oe_n_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = oe_n_r;

  // ****************************************************************
  // write commit at stop and busy timing
  // ****************************************************************
  wire logic        commit  = stop_ev & (ph_r == PH_WR);
  wire logic        c_send  = commit & (wcnt_r == 2'h0);
  wire logic        c_byte  = commit & (wcnt_r != 2'h0);
  wire logic        c_word  = commit & wcnt_r[1];
  wire logic [15:0] wdata   = {hi_r, lo_r};
  wire logic        clr_ev  = c_send & (cmd_r == `PMSF_C_CLRF);
  wire logic        store_ev = c_send & (cmd_r == `PMSF_C_STORE);
  wire logic        rest_ev = c_send & (cmd_r == `PMSF_C_RESTORE);
  wire logic        busy_fault_ev = scl_fall & ~ack_slot_r & (bitcnt_r == 4'h8)
                                  & (ph_r == PH_CMD) & ~c_ok;

  function automatic logic [24:0] busy_len(input logic [7:0] c, input logic s,
                                           input logic b, input logic w);
    busy_len = 25'h000_0000;
    if (s && c == `PMSF_C_RESTORE) busy_len = 25'(RESTORE_CYC);
    if (s && c == `PMSF_C_STORE) busy_len = 25'(STORE_CYC);
    if (w && (c == `PMSF_C_SGAIN || c == `PMSF_C_ISGAIN)) busy_len = 25'(LONG_CYC);
    if ((b && c == `PMSF_C_CONFIG) || (w && (c == `PMSF_C_AUX0 || c == `PMSF_C_AUX1
        || c == `PMSF_C_TRISE || c == `PMSF_C_OVL || c == `PMSF_C_UVL
        || c == `PMSF_C_DAC))) busy_len = 25'(SHORT_CYC);
  endfunction : busy_len

  wire logic [24:0] busy_load = busy_len(cmd_r, c_send, c_byte, c_word);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_r <= 25'h000_0000;
    end else if (busy_load != 25'h000_0000) begin
      busy_cnt_r <= busy_load;
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r - 25'h000_0001;
    end
  end

  // alert response releases the pin; the fault bit stays until cleared
  wire logic ara_done = stop_ev & ara_r & (ph_r == PH_RD || ph_r == PH_SKIP);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_fault_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      busy_fault_r <= busy_fault_ev | (busy_fault_r & ~clr_ev);
      alert_r <= busy_fault_ev | (alert_r & ~clr_ev & ~ara_done);
    end
  end

  assign alert_out_n = 1'b0;
  assign alert_oe_n  = ~alert_r;
  assign nvm_store_req   = store_ev;
  assign nvm_restore_req = rest_ev;

  // ****************************************************************
  // unpaged registers
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      page_r <= `PMSF_R_PAGE;
      wlock_r <= `PMSF_R_WLOCK;
      base_r <= `PMSF_BASE_RST;
      input_on_threshold_r <= `PMSF_R_VINON;
      input_off_threshold_r <= `PMSF_R_VINOFF;
    end else begin
      if (c_byte && cmd_r == `PMSF_C_PAGE) page_r <= lo_r;
      if (c_byte && cmd_r == `PMSF_C_WLOCK) wlock_r <= lo_r;
      if (c_byte && cmd_r == `PMSF_C_BASE) base_r <= lo_r[6:0];
      if (c_word && cmd_r == `PMSF_C_VINON) input_on_threshold_r <= wdata;
      if (c_word && cmd_r == `PMSF_C_VINOFF) input_off_threshold_r <= wdata;
    end
  end

  // ****************************************************************
  // input voltage gating
  // ****************************************************************
  logic        vin_ok_r, run_r;
  logic [16:0] toff_cnt_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vin_ok_r <= 1'b0;
      run_r <= 1'b0;
      toff_cnt_r <= 17'h0_0000;
    end else begin
      if (vin_meas > input_on_threshold_r) vin_ok_r <= 1'b1;
      else if (vin_meas < input_off_threshold_r) vin_ok_r <= 1'b0;
      if (vin_ok_r) begin
        run_r <= 1'b1;
        toff_cnt_r <= 17'(TOFF_CYC);
      end else if (!input_off_threshold_delayed || toff_cnt_r == 17'h0_0000) begin
        run_r <= 1'b0;
      end else begin
        toff_cnt_r <= toff_cnt_r - 17'h0_0001;
      end
    end
  end

  // ****************************************************************
  // paged registers, one copy per channel
  // ****************************************************************
  logic [15:0] setp_r [2];
  logic [1:0]  en_r, flt_r;

  for (genvar ch = 0; ch < 2; ch++) begin : g_page
    wire logic       mine = sel == 1'(ch);
    wire logic [1:0] marg = pg_r[ch].oper[5:4];
    wire logic [15:0] want = (marg == 2'b10) ? pg_r[ch].mhi :
                             (marg == 2'b01) ? pg_r[ch].mlo : pg_r[ch].vcmd;
    wire logic       b_wr = c_byte & mine;
    wire logic       w_wr = c_word & mine;

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        pg_r[ch] <= {`PMSF_R_OPER, `PMSF_R_ONOFF, `PMSF_R_VCMD, `PMSF_R_VMAX,
                     `PMSF_R_MHI, `PMSF_R_MLO, `PMSF_R_SGAIN, `PMSF_R_SOFFS,
                     `PMSF_R_OVL, `PMSF_R_OVA, `PMSF_R_OVW, `PMSF_R_UVW};
      end else begin
        if (b_wr && cmd_r == `PMSF_C_OPER) pg_r[ch].oper <= lo_r;
        if (b_wr && cmd_r == `PMSF_C_ONOFF) pg_r[ch].onoff <= lo_r;
        if (w_wr && cmd_r == `PMSF_C_VCMD) pg_r[ch].vcmd <= wdata;
        if (w_wr && cmd_r == `PMSF_C_VMAX) pg_r[ch].vmax <= wdata;
        if (w_wr && cmd_r == `PMSF_C_MHI) pg_r[ch].mhi <= wdata;
        if (w_wr && cmd_r == `PMSF_C_MLO) pg_r[ch].mlo <= wdata;
        if (w_wr && cmd_r == `PMSF_C_SGAIN) pg_r[ch].sgain <= wdata;
        if (w_wr && cmd_r == `PMSF_C_SOFFS) pg_r[ch].soffs <= wdata;
        if (w_wr && cmd_r == `PMSF_C_OVL) pg_r[ch].ovl <= wdata;
        if (b_wr && cmd_r == `PMSF_C_OVA) pg_r[ch].ova <= lo_r;
        if (w_wr && cmd_r == `PMSF_C_OVW) pg_r[ch].ovw <= wdata;
        if (w_wr && cmd_r == `PMSF_C_UVW) pg_r[ch].uvw <= wdata;
      end
    end

    // set wins over a clear in the same cycle so no fault is lost
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        flt_r[ch] <= 1'b0;
        en_r[ch] <= 1'b0;
        setp_r[ch] <= 16'h0000;
      end else begin
        flt_r[ch] <= fault_event[ch] | (flt_r[ch] & ~(clr_ev & mine));
        en_r[ch] <= pg_r[ch].oper[`PMSF_B_ON] & run_r;
        setp_r[ch] <= (want > pg_r[ch].vmax) ? pg_r[ch].vmax : want;
      end
    end
  end

  assign fault_latched     = flt_r;
  assign output_enable_pin = en_r;
  assign vout_setpoint0    = setp_r[0];
  assign vout_setpoint1    = setp_r[1];
endmodule : pmsf_top

// [tb/pmsf_host.sv]
`timescale 1ns/1ps
// ****
// smbus host model
// ****
module pmsf_host (
  input  wire logic clock,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // 125 ns bits, long low phase so the device's synced ack lands before scl rises
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #25;
    sda_low = !b;
    #50;
    scl = 1'b1;
    #25;
    r = sda;
    #25;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask : byte_io
  task automatic start(input logic rep);
    if (rep) begin
      scl = 1'b0;
      #75;
      scl = 1'b1;
      #25;
    end
    sda_low = 1'b1;
    #50;
  endtask : start
  task automatic stop();
    scl = 1'b0;
    #25;
    sda_low = 1'b1;
    #50;
    scl = 1'b1;
    #25;
    sda_low = 1'b0;
    #125;
  endtask : stop
  task automatic xact(input logic [6:0] a, input logic [7:0] c, input int nw,
                      input logic [15:0] wd, input logic rd, output logic [15:0] q,
                      output logic [1:0] ak);
    logic [7:0] b;
    logic       k;
    @(posedge clock);
    #1;
    start(1'b0);
    byte_io({a, 1'b0}, 1'b1, b, ak[1]);
    byte_io(c, 1'b1, b, ak[0]);
    for (int i = 0; i < nw; i++)
      byte_io(wd[8*i +: 8], 1'b1, b, k);
    if (rd) begin
      start(1'b1);
      byte_io({a, 1'b1}, 1'b1, b, k);
      byte_io(8'hFF, 1'b0, q[7:0], k);
      byte_io(8'hFF, 1'b1, q[15:8], k);
    end
    stop();
  endtask : xact
  task automatic ara(output logic [7:0] q);
    logic [7:0] b;
    logic       k;
    @(posedge clock);
    #1;
    start(1'b0);
    byte_io(8'h19, 1'b1, b, k);
    byte_io(8'hFF, 1'b1, q, k);
    stop();
  endtask : ara
endmodule : pmsf_host

// [tb/pmsf_checker.sv]
`timescale 1ns/1ps
// ****
// port checker
// ****
module pmsf_checker (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        alert_out_n,
  input wire logic        alert_oe_n,
  input wire logic [15:0] vin_meas,
  input wire logic        input_off_threshold_delayed,
  input wire logic [1:0]  fault_event,
  input wire logic [1:0]  fault_latched,
  input wire logic [1:0]  output_enable_pin,
  input wire logic        nvm_store_req,
  input wire logic        nvm_restore_req
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  AST_SDA_VALUE: assert property (sda_out == 1'b0)
    else $error("sda drive value not zero");
  AST_ALERT_VALUE: assert property (alert_out_n == 1'b0)
    else $error("alert drive value not zero");
  AST_STORE_PULSE: assert property (nvm_store_req |=> !nvm_store_req)
    else $error("store request too long");
  AST_RESTORE_PULSE: assert property (nvm_restore_req |=> !nvm_restore_req)
    else $error("restore request too long");
  AST_NVM_AT_STOP: assert property ((nvm_store_req || nvm_restore_req) |-> scl_in && sda_in)
    else $error("memory request with bus not idle");
  AST_FAULT_SET: assert property (fault_event[0] |=> fault_latched[0])
    else $error("fault event not latched");
  AST_FAULT_CLEAR: assert property ($fell(fault_latched[0]) |-> scl_in && sda_in)
    else $error("fault cleared outside a stop");
  // a data change with scl high would read as a start or stop
  AST_ACK_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda drive changed while scl high");
  AST_ALERT_ON_NACK: assert property ($fell(alert_oe_n) |-> sda_oe_n)
    else $error("alert raised while acking");
  AST_VIN_CUT: assert property ((!input_off_threshold_delayed && vin_meas < 16'hD240) [*3]
    |=> output_enable_pin == 2'b00) else $error("enables on below off level");
endmodule : pmsf_checker
bind pmsf_top pmsf_checker u_chk (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .alert_out_n(alert_out_n), .alert_oe_n(alert_oe_n),
  .vin_meas(vin_meas), .input_off_threshold_delayed(input_off_threshold_delayed), .fault_event(fault_event),
  .fault_latched(fault_latched), .output_enable_pin(output_enable_pin),
  .nvm_store_req(nvm_store_req), .nvm_restore_req(nvm_restore_req));

// [tb/tb_top.sv]
`timescale 1ns/1ps
// ****
// front end bench
// ****
module tb_top;
  import pmsf_pkg::*;
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  logic         scl, host_low, sda_out, sda_oe_n, alert_out_n, alert_oe_n, st, rs;
  pmsf_strap_s  strap = '0;
  logic [15:0]  vin_meas = 16'hD300;
  logic [1:0]   fault_event = 2'b00;
  logic         voff = 1'b0;
  logic [1:0]   fault_latched, oe, k;
  logic [1:0]   got = 2'b00;
  logic [15:0]  sp0, sp1, q;
  logic [7:0]   ab;
  logic [6:0]   own = 7'h5C;
  int           mismatches = 0;
  int           n_tests = 0;
  wire logic    sda_w = !(host_low || (!sda_oe_n && !sda_out));
  logic [7:0]   rc [19] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h24, 8'h25,
                  8'h26, 8'h35, 8'h36, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'hE6};
  logic [15:0]  rv [19] = '{16'h0000, 16'h0000, 16'h001E, 16'h0000, 16'h00B0, 16'h0013,
                  16'h2000, 16'h8000, 16'h219A, 16'h1E66, 16'hD280, 16'hD240, 16'hBA00,
                  16'h8000, 16'h2333, 16'h0080, 16'h2266, 16'h1D9A, 16'h005C};
  pmsf_top #(.RESTORE_CYC(1500), .STORE_CYC(2000), .LONG_CYC(600), .SHORT_CYC(300),
    .TOFF_CYC(100)) DUT (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_in(strap), .alert_out_n(alert_out_n),
    .alert_oe_n(alert_oe_n), .vin_meas(vin_meas), .input_off_threshold_delayed(voff),
    .fault_event(fault_event), .fault_latched(fault_latched), .output_enable_pin(oe),
    .vout_setpoint0(sp0), .vout_setpoint1(sp1), .nvm_store_req(st), .nvm_restore_req(rs));
  pmsf_host host (.clock(clock), .scl(scl), .sda_low(host_low), .sda(sda_w));
  always #5 clock = !clock;
  always @(posedge clock) got <= got | {rs, st};
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    host.xact(own, c, n, d, 1'b0, q, k);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    host.xact(a, c, 0, 16'h0000, 1'b1, q, k);
  endtask : rd
  task automatic stat(input logic [15:0] e);
    rd(own, 8'hE5);
    chk("status", e, q & 16'h0042);
  endtask : stat
  // bounded so a stuck busy flag ends as a mismatch, not a hang
  task automatic poll();
    q = 16'h0000;
    for (int i = 0; i < 40 && q[6] !== 1'b1; i++)
      rd(own, 8'hE5);
    chk("ready", 16'h0040, q & 16'h0040);
  endtask : poll
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  initial begin
    #1_000_000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 19; i++) begin
      rd(own, rc[i]);
      chk("reset value", rv[i], q);
    end
    for (int h = 0; h < 3; h++)
      for (int l = 0; l < 3; l++) begin
        @(posedge clock);
        strap <= '{low_digit: 2'(l), high_digit: 2'(h)};
        own = 7'(7'h5C + 3 * h + l);
        rd(own, 8'hE5);
        chk("strap acks", 16'h0003, {14'h0, k});
      end
    rd(7'h65, 8'hE5);
    chk("foreign acks", 16'h0000, {14'h0, k});
    rd(7'h5B, 8'hE5);
    chk("global acks", 16'h0003, {14'h0, k});
    wr(8'hE6, 1, 16'h0010);
    own = 7'h18;
    rd(own, 8'hE6);
    chk("base", 16'h0010, q);
    wr(8'hE6, 1, 16'h005C);
    own = 7'h64;
    wr(8'h20, 1, 16'h0055);
    rd(own, 8'h20);
    chk("format", 16'h0013, q);
    wr(8'h00, 1, 16'h0001);
    wr(8'h21, 2, 16'h1111);
    wr(8'h24, 2, 16'h1000);
    rd(own, 8'h21);
    chk("page1 target", 16'h1111, q);
    chk("capped setpoint", 16'h1000, sp1);
    wr(8'h00, 1, 16'h0000);
    rd(own, 8'h21);
    chk("page0 target", 16'h2000, q);
    wr(8'h01, 1, 16'h00A0);
    chk("margin setpoint", 16'h219A, sp0);
    chk("enables", 16'h0001, {14'h0, oe});
    vin_meas <= 16'hD000;
    repeat (6) @(posedge clock);
    chk("enables", 16'h0000, {14'h0, oe});
    vin_meas <= 16'hD300;
    voff <= 1'b1;
    repeat (6) @(posedge clock);
    chk("enables", 16'h0001, {14'h0, oe});
    vin_meas <= 16'hD000;
    repeat (6) @(posedge clock);
    chk("delayed enables", 16'h0001, {14'h0, oe});
    repeat (110) @(posedge clock);
    chk("delayed enables", 16'h0000, {14'h0, oe});
    vin_meas <= 16'hD300;
    fault_event <= 2'b01;
    @(posedge clock);
    fault_event <= 2'b00;
    @(posedge clock);
    chk("fault latch", 16'h0001, {14'h0, fault_latched});
    wr(8'h15, 0, 16'h0000);
    stat(16'h0000);
    wr(8'h01, 1, 16'h0080);
    chk("busy acks", 16'h0002, {14'h0, k});
    chk("alert", 16'h0000, {15'h0, alert_oe_n});
    stat(16'h0002);
    poll();
    host.ara(ab);
    chk("ara", {8'h00, own, 1'b0}, {8'h00, ab});
    chk("alert", 16'h0001, {15'h0, alert_oe_n});
    wr(8'h03, 0, 16'h0000);
    stat(16'h0040);
    chk("fault latch", 16'h0000, {14'h0, fault_latched});
    wr(8'h38, 2, 16'hBA00);
    stat(16'h0000);
    poll();
    wr(8'h16, 0, 16'h0000);
    poll();
    chk("nvm pulses", 16'h0003, {14'h0, got});
    conclude();
  end
endmodule : tb_top
